// ===== dv/dcs_host_model.sv
// host-side model: axi4-lite master plus zero and ranging helpers
`timescale 1ns/1ps
module dcs_host_model (
    input wire logic aclk,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    initial begin
        awaddr = 8'h00;
        awvalid = 1'b0;
        wdata = 32'h0;
        wstrb = 4'hF;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = 8'h00;
        arvalid = 1'b0;
        rready = 1'b0;
    end
    // valid and ready looked at on the rising edge, so a hand-off is never missed
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic tb;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        tb = 1'b0;
        while (!tb) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                tb = 1'b1;
                r = bresp;
                bready <= 1'b0;
            end
        end
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic tr;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        tr = 1'b0;
        while (!tr) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                tr = 1'b1;
                d = rdata;
                r = rresp;
                rready <= 1'b0;
            end
        end
    endtask : rd
    // zero request, repeated whenever common mode or reference moves
    task automatic zero_conv(input logic [5:0] ctrl, output logic [1:0] r);
        wr(dcs_pkg::OFS_CTRL, {26'h0, ctrl | 6'h01}, r);
    endtask : zero_conv
    // one range up after overload; hysteresis stays with the host
    task automatic range_up(input logic [2:0] cur, output logic [1:0] r);
        wr(dcs_pkg::OFS_RANGE, {29'h0, cur + 3'h1}, r);
    endtask : range_up
    // host zero correction works on signed counts; upper half of the word is negative
    function automatic int bcd9_value(input logic [19:0] w);
        int v;
        v = 0;
        for (int i = dcs_pkg::DIGITS - 1; i >= 0; i--) begin
            v = v * 10 + int'(w[i*4 +: 4]);
        end
        return (v >= 50000) ? v - 100000 : v;
    endfunction : bcd9_value
endmodule : dcs_host_model

// ===== dv/dmm_conversion_sequencer_test.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module dmm_conversion_sequencer_test;
    localparam int TDIV = 4;
    localparam int CONV = dcs_pkg::CONV_TICKS * TDIV;
    localparam int LIMIT = 95000;
    typedef struct {
        logic [5:0] ctrl;
        logic [2:0] rng;
        logic [11:0] outs;
        int ilen;
    } dcs_row_t;
    logic aclk, aresetn, comparator_in, dg;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, val;
    logic [19:0] zval;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic input_low_terminal_short, chop_swap, integrator_discharge, integrate_phase, rint_half;
    logic [4:0] range_switch;
    logic attenuator_route, current_route, low_level_to_common, current_to_common;
    logic acdc_insert, ohms_diode_source, ohms_ref_select;
    int err_total, num_checks, cyc, bad, hi, tot;
    dcs_row_t rows[4];
    dcs_sequencer #(.TICK_DIV(TDIV)) u_dcs_sequencer (
        .aclk, .aresetn, .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid), .s_axil_awready(awready),
        .s_axil_wdata(wdata), .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid), .s_axil_wready(wready),
        .s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready), .s_axil_araddr(araddr),
        .s_axil_arvalid(arvalid), .s_axil_arready(arready), .s_axil_rdata(rdata), .s_axil_rresp(rresp),
        .s_axil_rvalid(rvalid), .s_axil_rready(rready), .comparator_in, .input_low_terminal_short,
        .chop_swap, .integrator_discharge, .integrate_phase, .rint_half, .range_switch, .attenuator_route,
        .current_route, .low_level_to_common, .current_to_common, .acdc_insert, .ohms_diode_source,
        .ohms_ref_select
    );
    dcs_host_model u_dcs_host_model (
        .aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
    );
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    // comparator follows the chop so the result path moves
    always @(posedge aclk) begin
        comparator_in <= chop_swap ^ integrate_phase;
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            err_total++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    function automatic logic sig(input int k);
        case (k)
            0: return integrator_discharge;
            1: return integrate_phase;
            2: return chop_swap;
            default: return input_low_terminal_short;
        endcase
    endfunction : sig
    // waits for a fresh rise; hi counts high cycles, tot the full period when full is set, else equals hi
    task automatic meas(input int k, input bit full, output int h, output int t);
        h = 0;
        while (sig(k) !== 1'b0) @(negedge aclk);
        while (sig(k) !== 1'b1) @(negedge aclk);
        while (sig(k) === 1'b1) begin
            @(negedge aclk);
            h++;
            if (rint_half !== (dg & integrate_phase)) bad++;
        end
        t = h;
        while (full && sig(k) !== 1'b1) begin
            @(negedge aclk);
            t++;
        end
    endtask : meas
    initial begin
        rows[0] = '{6'h02, 3'h0, 12'h0C8, dcs_pkg::INT_50_TICKS * TDIV};
        rows[1] = '{6'h24, 3'h2, 12'h25C, dcs_pkg::INT_60_TICKS * TDIV};
        rows[2] = '{6'h10, 3'h7, 12'h830, dcs_pkg::INT_60_TICKS * TDIV};
        rows[3] = '{6'h0A, 3'h4, 12'h85B, dcs_pkg::INT_OHMS_TICKS * TDIV};
        aresetn = 1'b0;
        dg = 1'b0;
        repeat (19) @(posedge aclk);
        @(negedge aclk);
        chk("reset outs", 32'h10F0, {integrator_discharge, range_switch, attenuator_route, low_level_to_common,
            current_to_common, input_low_terminal_short, bvalid, rvalid, chop_swap});
        @(posedge aclk);
        aresetn <= 1'b1;
        u_dcs_host_model.rd(dcs_pkg::OFS_CTRL, val, resp);
        chk("ctrl reset", 32'h0, val);
        u_dcs_host_model.rd(dcs_pkg::OFS_RESULT, val, resp);
        chk("result reset", 32'h0, val);
        foreach (rows[i]) begin
            u_dcs_host_model.wr(dcs_pkg::OFS_CTRL, {26'h0, rows[i].ctrl}, resp);
            chk("ctrl bresp", {30'h0, dcs_pkg::RESP_OKAY}, {30'h0, resp});
            u_dcs_host_model.wr(dcs_pkg::OFS_RANGE, {29'h0, rows[i].rng}, resp);
            u_dcs_host_model.rd(dcs_pkg::OFS_RANGE, val, resp);
            chk("range reg", (rows[i].rng > 3'h4) ? 32'h4 : {29'h0, rows[i].rng}, val);
            dg = rows[i].ctrl[dcs_pkg::CTRL_DOUBLE_GAIN];
            bad = 0;
            meas(0, 1'b0, hi, tot);
            chk("discharge len", dcs_pkg::ZI_TICKS * TDIV, hi);
            meas(1, 1'b0, hi, tot);
            chk("integrate len", rows[i].ilen, hi);
            chk("rint_half", 32'h0, bad);
            chk("switches", {20'h0, rows[i].outs}, {20'h0, range_switch, attenuator_route, current_route,
                low_level_to_common, current_to_common, acdc_insert, ohms_diode_source, ohms_ref_select});
        end
        u_dcs_host_model.zero_conv(6'h02, resp);
        u_dcs_host_model.rd(dcs_pkg::OFS_CTRL, val, resp);
        chk("zero pending", 32'h3, val);
        meas(3, 1'b0, hi, tot);
        chk("zero short len", CONV, hi);
        repeat (4) @(negedge aclk);
        u_dcs_host_model.rd(dcs_pkg::OFS_RESULT, val, resp);
        chk("zero flag", 32'h1, {31'h0, val[20]});
        zval = val[19:0];
        bad = 0;
        for (int i = 0; i < dcs_pkg::DIGITS; i++) begin
            if (val[4 * i +: 4] > 4'h9) bad++;
        end
        chk("bcd digits", 32'h0, bad);
        meas(2, 1'b1, hi, tot);
        chk("chop high", CONV / 2, hi);
        chk("conv period", CONV, tot);
        u_dcs_host_model.rd(dcs_pkg::OFS_RESULT, val, resp);
        chk("normal flag", 32'h0, {31'h0, val[20]});
        // comparator pattern is the same in both conversions, so correction cancels
        hi = u_dcs_host_model.bcd9_value(val[19:0]) - u_dcs_host_model.bcd9_value(zval);
        chk("corrected", 32'h0, hi);
        u_dcs_host_model.rd(dcs_pkg::OFS_CTRL, val, resp);
        chk("zero cleared", 32'h2, val);
        u_dcs_host_model.rd(8'h14, val, resp);
        chk("unmapped rresp", {30'h0, dcs_pkg::RESP_SLVERR}, {30'h0, resp});
        u_dcs_host_model.wr(dcs_pkg::OFS_RESULT, 32'hFFFFF, resp);
        chk("result wr bresp", {30'h0, dcs_pkg::RESP_SLVERR}, {30'h0, resp});
        u_dcs_host_model.range_up(3'h3, resp);
        u_dcs_host_model.rd(dcs_pkg::OFS_RANGE, val, resp);
        chk("range up", 32'h4, val);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk("rerun reset", 32'h21, {integrator_discharge, range_switch});
        u_dcs_host_model.rd(dcs_pkg::OFS_CTRL, val, resp);
        chk("rerun ctrl", 32'h0, val);
        u_dcs_host_model.rd(dcs_pkg::OFS_RANGE, val, resp);
        chk("rerun range", 32'h0, val);
        close_out();
    end
endmodule : dmm_conversion_sequencer_test

// ===== src/dcs_pkg.sv
// shared constants for the conversion sequencer
package dcs_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_RANGE = 8'h04;
    localparam logic [7:0] OFS_RESULT = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_RAW = 8'h10;
    // control field positions
    localparam int CTRL_ZERO_REQ = 0;
    localparam int CTRL_LINE_50 = 1;
    localparam int CTRL_DOUBLE_GAIN = 2;
    localparam int CTRL_OHMS = 3;
    localparam int CTRL_CURRENT = 4;
    localparam int CTRL_AC = 5;
    // reset values
    localparam logic [5:0] CTRL_RESET = 6'h00;
    localparam logic [2:0] RANGE_RESET = 3'h0;
    localparam logic [19:0] RESULT_RESET = 20'h00000;
    // timing: conversion period and sequencer tick
    localparam int CONV_PERIOD_MS = 50;
    localparam int XTAL_HZ = 32768;
    localparam int CLK_HZ = 250000000;
    localparam int TICK_DIV = CLK_HZ / XTAL_HZ;
    localparam int CONV_TICKS = XTAL_HZ * CONV_PERIOD_MS / 1000;
    // phase lengths in crystal ticks
    localparam int ZI_TICKS = 200;
    localparam int INT_60_TICKS = 546;
    localparam int INT_50_TICKS = 655;
    localparam int INT_OHMS_TICKS = 500;
    // bcd digit count of the result
    localparam int DIGITS = 5;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {
        PH_ZERO_INT = 2'b00,
        PH_INTEGRATE = 2'b01,
        PH_DEINTEGRATE = 2'b10
    } dcs_phase_t;
endpackage : dcs_pkg

// ===== src/dcs_sequencer.sv
// conversion sequencer with axi4-lite control and result registers
// Contract
// - free-running raw conversion every 50 ms, fully self-timed
// - host-requested zero-reference conversion also takes 50 ms
// - during zero conversion low terminal is shorted to high terminal
// - input transistor polarity swaps partway through every conversion
// - each conversion end captures result into readable holding register
// - result is five-digit nines-complement bcd; -1 reads 99999
// - double gain halves integrator resistance during integrate phase only
// - double gain makes 200mV read full scale 4000.0
// - every conversion includes an integrator discharge phase
// - input mux routes attenuator or current-sense voltage by function
// - unselected 400mV or current input switched to common
// - ac function inserts external ac-dc converter into path
// - ohms mode integration fixed at 500 counts regardless of line bit
// - lowest ohms range enables diode-to-supply source switch
// - ohms mode uses reference resistor voltage as converter reference
// - sequence and measurement counters run on 32 kHz crystal tick
// - host control bit selects 50 Hz or 60 Hz rejection
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module dcs_sequencer #(
    parameter int TICK_DIV = dcs_pkg::TICK_DIV
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [7:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    input wire logic comparator_in,
    output logic input_low_terminal_short,
    output logic chop_swap,
    output logic integrator_discharge,
    output logic integrate_phase,
    output logic rint_half,
    output logic [4:0] range_switch,
    output logic attenuator_route,
    output logic current_route,
    output logic low_level_to_common,
    output logic current_to_common,
    output logic acdc_insert,
    output logic ohms_diode_source,
    output logic ohms_ref_select
);
    dcs_pkg::dcs_phase_t phase;
    logic [5:0] ctrl;
    logic [2:0] range_sel;
    logic zero_pending;
    logic zero_active;
    logic [19:0] result;
    logic result_is_zero;
    logic [15:0] seq_cnt;
    logic [15:0] meas_cnt;
    logic [15:0] div_cnt;
    logic tick;
    logic cmp_meta;
    logic cmp_sync;
    logic conv_done;
    logic [15:0] int_len;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // converts a count to nines-complement bcd, negative when sign set
    function automatic logic [19:0] to_bcd9(input logic [15:0] mag, input logic neg);
        logic [19:0] d;
        logic [16:0] v;
        d = 20'h00000;
        // negative counts wrap at five digits so that minus one reads all nines
        v = neg ? 17'h186A0 - {1'b0, mag} : {1'b0, mag};
        for (int i = 0; i < dcs_pkg::DIGITS; i++) begin
            d[i*4 +: 4] = 4'(v % 17'h0000A);
            v = v / 17'h0000A;
        end
        return d;
    endfunction : to_bcd9

    // crystal-rate tick from system clock
    always_ff @(posedge aclk) begin
        if (!aresetn || div_cnt == 16'(TICK_DIV - 1)) begin
            div_cnt <= 16'h0000;
        end else begin
            div_cnt <= div_cnt + 16'h0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick <= 1'b0;
        end else begin
            tick <= (div_cnt == 16'(TICK_DIV - 1));
        end
    end

    // comparator is analogue-side, so synchronise it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
        end else begin
            cmp_meta <= comparator_in;
            cmp_sync <= cmp_meta;
        end
    end

    // integrate length: ohms overrides the line bit
    always_comb begin
        if (ctrl[dcs_pkg::CTRL_OHMS]) begin
            int_len = 16'(dcs_pkg::INT_OHMS_TICKS);
        end else if (ctrl[dcs_pkg::CTRL_LINE_50]) begin
            int_len = 16'(dcs_pkg::INT_50_TICKS);
        end else begin
            int_len = 16'(dcs_pkg::INT_60_TICKS);
        end
    end

    assign conv_done = tick && seq_cnt == 16'(dcs_pkg::CONV_TICKS - 1);

    // sequence counter: fixed period independent of mode
    always_ff @(posedge aclk) begin
        if (!aresetn || conv_done) begin
            seq_cnt <= 16'h0000;
        end else if (tick) begin
            seq_cnt <= seq_cnt + 16'h0001;
        end
    end

    // phase machine: zero-integrate, integrate, deintegrate
    always_ff @(posedge aclk) begin
        if (!aresetn || conv_done) begin
            phase <= dcs_pkg::PH_ZERO_INT;
        end else if (tick) begin
            case (phase)
                dcs_pkg::PH_ZERO_INT: begin
                    if (seq_cnt == 16'(dcs_pkg::ZI_TICKS - 1)) begin
                        phase <= dcs_pkg::PH_INTEGRATE;
                    end
                end
                dcs_pkg::PH_INTEGRATE: begin
                    if (seq_cnt == 16'(dcs_pkg::ZI_TICKS - 1) + int_len) begin
                        phase <= dcs_pkg::PH_DEINTEGRATE;
                    end
                end
                default: phase <= phase;
            endcase
        end
    end

    // deintegrate counter; comparator low means crossing reached
    always_ff @(posedge aclk) begin
        if (!aresetn || conv_done) begin
            meas_cnt <= 16'h0000;
        end else if (tick && phase == dcs_pkg::PH_DEINTEGRATE && cmp_sync) begin
            meas_cnt <= meas_cnt + 16'h0001;
        end
    end

    // zero request latched; active for the whole next conversion
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            zero_active <= 1'b0;
        end else if (conv_done) begin
            zero_active <= zero_pending;
        end
    end

    // holding register: all digits in one edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result <= dcs_pkg::RESULT_RESET;
            result_is_zero <= 1'b0;
        end else if (conv_done) begin
            result <= to_bcd9(meas_cnt, chop_swap ^ cmp_sync);
            result_is_zero <= zero_active;
        end
    end

    // switch outputs, registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            input_low_terminal_short <= 1'b0;
            chop_swap <= 1'b0;
            integrator_discharge <= 1'b1;
            integrate_phase <= 1'b0;
            rint_half <= 1'b0;
            range_switch <= 5'h01;
            attenuator_route <= 1'b1;
            current_route <= 1'b0;
            low_level_to_common <= 1'b1;
            current_to_common <= 1'b1;
            acdc_insert <= 1'b0;
            ohms_diode_source <= 1'b0;
            ohms_ref_select <= 1'b0;
        end else begin
            input_low_terminal_short <= zero_active;
            // chop midway through the conversion period
            chop_swap <= seq_cnt >= 16'(dcs_pkg::CONV_TICKS / 2);
            integrator_discharge <= phase == dcs_pkg::PH_ZERO_INT;
            integrate_phase <= phase == dcs_pkg::PH_INTEGRATE;
            // gain doubling limited to integrate so deintegrate scale holds
            rint_half <= ctrl[dcs_pkg::CTRL_DOUBLE_GAIN]
                && phase == dcs_pkg::PH_INTEGRATE;
            range_switch <= 5'(5'h01 << range_sel);
            attenuator_route <= !ctrl[dcs_pkg::CTRL_CURRENT];
            current_route <= ctrl[dcs_pkg::CTRL_CURRENT];
            low_level_to_common <= ctrl[dcs_pkg::CTRL_CURRENT] || range_sel != 3'h0;
            current_to_common <= !ctrl[dcs_pkg::CTRL_CURRENT];
            acdc_insert <= ctrl[dcs_pkg::CTRL_AC];
            // lowest ohms range shares the smallest attenuator resistor, range 4
            ohms_diode_source <= ctrl[dcs_pkg::CTRL_OHMS] && range_sel == 3'h4;
            ohms_ref_select <= ctrl[dcs_pkg::CTRL_OHMS];
        end
    end

    // axi write path: address and data taken independently
    assign s_axil_awready = !aw_held && !s_axil_bvalid;
    assign s_axil_wready = !w_held && !s_axil_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axil_bvalid <= 1'b0;
            s_axil_bresp <= dcs_pkg::RESP_OKAY;
        end else begin
            if (s_axil_awvalid && s_axil_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axil_awaddr;
            end
            if (s_axil_wvalid && s_axil_wready) begin
                w_held <= 1'b1;
                w_data <= s_axil_wdata;
                w_strb <= s_axil_wstrb;
            end
            if (aw_held && w_held) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axil_bvalid <= 1'b1;
                s_axil_bresp <= (aw_addr == dcs_pkg::OFS_CTRL || aw_addr == dcs_pkg::OFS_RANGE)
                    ? dcs_pkg::RESP_OKAY : dcs_pkg::RESP_SLVERR;
            end else if (s_axil_bvalid && s_axil_bready) begin
                s_axil_bvalid <= 1'b0;
            end
        end
    end

    // control and range registers, byte lane 0
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= dcs_pkg::CTRL_RESET;
            range_sel <= dcs_pkg::RANGE_RESET;
        end else if (aw_held && w_held && w_strb[0]) begin
            if (aw_addr == dcs_pkg::OFS_CTRL) begin
                ctrl <= w_data[5:0];
            end else if (aw_addr == dcs_pkg::OFS_RANGE) begin
                range_sel <= (w_data[2:0] > 3'h4) ? 3'h4 : w_data[2:0];
            end
        end
    end

    // zero request: hardware consumption at cycle start, write sets
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            zero_pending <= 1'b0;
        end else if (aw_held && w_held && w_strb[0] && aw_addr == dcs_pkg::OFS_CTRL
                && w_data[dcs_pkg::CTRL_ZERO_REQ]) begin
            zero_pending <= 1'b1;
        end else if (conv_done) begin
            zero_pending <= 1'b0;
        end
    end

    // axi read path
    assign s_axil_arready = !s_axil_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axil_rvalid <= 1'b0;
            s_axil_rdata <= 32'h00000000;
            s_axil_rresp <= dcs_pkg::RESP_OKAY;
        end else if (s_axil_arvalid && s_axil_arready) begin
            s_axil_rvalid <= 1'b1;
            s_axil_rresp <= dcs_pkg::RESP_OKAY;
            if (s_axil_araddr == dcs_pkg::OFS_CTRL) begin
                s_axil_rdata <= {26'h0000000, ctrl[5:1], zero_pending};
            end else if (s_axil_araddr == dcs_pkg::OFS_RANGE) begin
                s_axil_rdata <= {29'h00000000, range_sel};
            end else if (s_axil_araddr == dcs_pkg::OFS_RESULT) begin
                s_axil_rdata <= {11'h000, result_is_zero, result};
            end else if (s_axil_araddr == dcs_pkg::OFS_STATUS) begin
                s_axil_rdata <= {28'h0000000, zero_active, 1'b0, 2'(phase)};
            end else begin
                s_axil_rdata <= 32'h00000000;
                s_axil_rresp <= dcs_pkg::RESP_SLVERR;
            end
        end else if (s_axil_rready) begin
            s_axil_rvalid <= 1'b0;
        end
    end

    // assertions
    property p_short_follows_zero;
        @(posedge aclk) disable iff (!aresetn) zero_active |=> input_low_terminal_short;
    endproperty
    a_short_follows_zero: assert property (p_short_follows_zero) else $error("short missing");
    property p_gain_integrate_only;
        @(posedge aclk) disable iff (!aresetn) rint_half |-> $past(phase) == dcs_pkg::PH_INTEGRATE;
    endproperty
    a_gain_integrate_only: assert property (p_gain_integrate_only) else $error("half rint outside");
    property p_discharge_at_start;
        @(posedge aclk) disable iff (!aresetn) conv_done |=> ##1 integrator_discharge;
    endproperty
    a_discharge_at_start: assert property (p_discharge_at_start) else $error("no discharge");
    property p_result_stable;
        @(posedge aclk) disable iff (!aresetn) !$past(conv_done) |-> $stable(result);
    endproperty
    a_result_stable: assert property (p_result_stable) else $error("result torn");
    property p_ohms_len;
        @(posedge aclk) disable iff (!aresetn) ctrl[dcs_pkg::CTRL_OHMS] |-> int_len == 16'h01F4;
    endproperty
    a_ohms_len: assert property (p_ohms_len) else $error("ohms length");
    property p_diode;
        @(posedge aclk) disable iff (!aresetn)
            (ctrl[dcs_pkg::CTRL_OHMS] && range_sel == 3'h4) |=> ohms_diode_source;
    endproperty
    a_diode: assert property (p_diode) else $error("diode switch");
    property p_route_excl;
        @(posedge aclk) disable iff (!aresetn) !(attenuator_route && current_route);
    endproperty
    a_route_excl: assert property (p_route_excl) else $error("both routes");
    property p_ac;
        @(posedge aclk) disable iff (!aresetn) ctrl[dcs_pkg::CTRL_AC] |=> acdc_insert;
    endproperty
    a_ac: assert property (p_ac) else $error("ac path");
    c_conv: cover property (@(posedge aclk) conv_done);
    c_zero: cover property (@(posedge aclk) conv_done && zero_active);
    c_gain: cover property (@(posedge aclk) rint_half);
    c_diode: cover property (@(posedge aclk) ohms_diode_source);
endmodule : dcs_sequencer
